// File: hw/flash_seq_pkg.sv
// constants and types shared by the parallel flash write sequencer
// Notes on behaviour
// - host writes: write strobe low, chip select low
// - host programs single bytes into erased sectors
// - program: three unlock writes, then address/data
// - sector erase: six writes, sector on last
// - chip erase: six writes, code at fixed address
// - after doubtful status, reread twice before accepting
package flash_seq_pkg;

  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_PROG   = 2'h1,
    OP_SECTOR = 2'h2,
    OP_CHIP   = 2'h3
  } flash_op_e;

  localparam int CLK_PERIOD_NS = 100;

  // longest internal program time, rounded down to whole cycles
  localparam int PROG_MAX_NS  = 20000;
  localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;

  // least settling time before the whole byte is trusted, rounded up
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // erase limits are not bounded by the part; generous defaults
  localparam int SECTOR_TIMEOUT_CYC = 250000;
  localparam int CHIP_TIMEOUT_CYC   = 1000000;

  localparam logic [3:0] WE_LOW_CYC = 4'h1;
  localparam logic [3:0] READ_CYC   = 4'h2;

  localparam int PROG_LEN  = 4;
  localparam int ERASE_LEN = 6;

  localparam int  SECTOR_BITS   = 12;
  localparam logic [7:0] SECTOR_ERASE_CODE = 8'h30;
  localparam logic [7:0] CHIP_ERASE_CODE   = 8'h10;
  localparam logic [7:0] ERASED_BYTE       = 8'hff;
  localparam logic [15:0] CHIP_ERASE_ADDR  = 16'h5555;

  // unlock values: plain defaults, override to suit the attached part
  localparam logic [15:0] UNLOCK_ADDR_A  = 16'h5555;
  localparam logic [15:0] UNLOCK_ADDR_B  = 16'h2aaa;
  localparam logic [7:0]  UNLOCK_CODE_A  = 8'haa;
  localparam logic [7:0]  UNLOCK_CODE_B  = 8'h55;
  localparam logic [7:0]  PROG_SETUP     = 8'ha0;
  localparam logic [7:0]  ERASE_SETUP    = 8'h80;

endpackage

// File: hw/bus_cycle_if.sv
// one pin-level bus cycle request between sequencer and cycle engine
`timescale 1ns/1ns
interface bus_cycle_if #(parameter int ADDR_W = 19);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              done;
  logic [7:0]        rdata;

  modport seq    (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// File: hw/flash_bus_cycle.sv
// single read or write cycle on the asynchronous flash pins
`timescale 1ns/1ns
module flash_bus_cycle #(
  parameter int ADDR_W = 19
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // cycle requests
  bus_cycle_if.engine            bc,
  // flash pins
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic [ADDR_W-1:0]      addr,
  output logic [7:0]             dq_out,
  output logic                   dq_oe,
  input  wire logic [7:0]        dq_in
);
  import flash_seq_pkg::*;

  typedef enum logic [1:0] {
    CYC_IDLE   = 2'b00,
    CYC_SETUP  = 2'b01,
    CYC_STROBE = 2'b11,
    CYC_HOLD   = 2'b10
  } cyc_st_e;

  typedef struct packed {
    cyc_st_e           st;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [3:0]        cnt;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe;
    logic              done;
  } cyc_s;

  cyc_s state_ff;
  cyc_s nxt_ff;

  always_comb begin
    nxt_ff      = state_ff;
    nxt_ff.done = 1'b0;
    case (state_ff.st)
      CYC_IDLE: begin
        if (bc.req) begin
          nxt_ff.st    = CYC_SETUP;
          nxt_ff.wr    = bc.wr;
          nxt_ff.addr  = bc.addr;
          nxt_ff.wdata = bc.wdata;
          nxt_ff.ce_n  = 1'b0;
          nxt_ff.dq_oe = bc.wr;
        end
      end
      CYC_SETUP: begin
        nxt_ff.st  = CYC_STROBE;
        nxt_ff.cnt = 4'h0;
        if (state_ff.wr) begin
          // strobe falls after chip select, so the address is taken here
          nxt_ff.we_n = 1'b0;
        end else begin
          nxt_ff.oe_n = 1'b0;
        end
      end
      CYC_STROBE: begin
        nxt_ff.cnt = state_ff.cnt + 4'h1;
        if (state_ff.cnt == (state_ff.wr ? WE_LOW_CYC : READ_CYC) - 4'h1) begin
          nxt_ff.st = CYC_HOLD;
          if (state_ff.wr) begin
            // data stays driven across the strobe's rise
            nxt_ff.we_n = 1'b1;
          end else begin
            nxt_ff.oe_n  = 1'b1;
            nxt_ff.rdata = dq_in;
          end
        end
      end
      CYC_HOLD: begin
        nxt_ff.st    = CYC_IDLE;
        nxt_ff.ce_n  = 1'b1;
        nxt_ff.dq_oe = 1'b0;
        nxt_ff.done  = 1'b1;
      end
      default: begin
        nxt_ff = state_ff;
        nxt_ff.st = CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff       <= '0;
      state_ff.ce_n  <= 1'b1;
      state_ff.oe_n  <= 1'b1;
      state_ff.we_n  <= 1'b1;
    end else begin
      state_ff <= nxt_ff;
    end
  end

  // output gate never falls during a write, so no write is ever blocked
  assign oe_n     = state_ff.oe_n;
  assign ce_n     = state_ff.ce_n;
  assign we_n     = state_ff.we_n;
  assign addr     = state_ff.addr;
  assign dq_out   = state_ff.wdata;
  assign dq_oe    = state_ff.dq_oe;
  assign bc.done  = state_ff.done;
  assign bc.rdata = state_ff.rdata;
endmodule

// File: hw/flash_write_seq.sv
// host sequencer: reads, byte program and erases on a parallel flash
`timescale 1ns/1ns
module flash_write_seq #(
  parameter int          ADDR_W         = 19,
  parameter int          TMR_W          = 24,
  parameter int          SECTOR_TIMEOUT = flash_seq_pkg::SECTOR_TIMEOUT_CYC,
  parameter int          CHIP_TIMEOUT   = flash_seq_pkg::CHIP_TIMEOUT_CYC,
  parameter logic [15:0] UNLOCK_ADDR_A  = flash_seq_pkg::UNLOCK_ADDR_A,
  parameter logic [15:0] UNLOCK_ADDR_B  = flash_seq_pkg::UNLOCK_ADDR_B,
  parameter logic [7:0]  UNLOCK_CODE_A  = flash_seq_pkg::UNLOCK_CODE_A,
  parameter logic [7:0]  UNLOCK_CODE_B  = flash_seq_pkg::UNLOCK_CODE_B,
  parameter logic [7:0]  PROG_SETUP     = flash_seq_pkg::PROG_SETUP,
  parameter logic [7:0]  ERASE_SETUP    = flash_seq_pkg::ERASE_SETUP
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // command port
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire flash_seq_pkg::flash_op_e cmd_op,
  input  wire logic [ADDR_W-1:0]       cmd_addr,
  input  wire logic [7:0]              cmd_data,
  // answer port
  output logic                         rsp_valid,
  output logic [7:0]                   rsp_data,
  output logic                         rsp_error,
  output logic                         busy,
  // flash pins
  output logic                         ce_n,
  output logic                         oe_n,
  output logic                         we_n,
  output logic [ADDR_W-1:0]            addr,
  output logic [7:0]                   dq_out,
  output logic                         dq_oe,
  input  wire logic [7:0]              dq_in
);
  import flash_seq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SEQ     = 3'b001,
    ST_POLL    = 3'b011,
    ST_CONFIRM = 3'b010,
    ST_SETTLE  = 3'b110,
    ST_FINAL   = 3'b111
  } main_st_e;

  typedef struct packed {
    main_st_e          st;
    flash_op_e         op;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [2:0]        step;
    logic              pend;
    logic              conf;
    logic [TMR_W-1:0]  tmr;
    logic              rsp_valid;
    logic              rsp_error;
    logic [7:0]        rsp_data;
  } seq_s;

  seq_s state_ff;
  seq_s nxt_ff;

  bus_cycle_if #(.ADDR_W(ADDR_W)) bc ();

  function automatic logic [ADDR_W-1:0] widen(input logic [15:0] a);
    widen = ADDR_W'(a);
  endfunction

  function automatic logic [2:0] last_step(input flash_op_e op);
    last_step = (op == OP_PROG) ? 3'(PROG_LEN - 1) : 3'(ERASE_LEN - 1);
  endfunction

  function automatic logic [ADDR_W-1:0] step_addr(input flash_op_e op, input logic [2:0] s,
                                                  input logic [ADDR_W-1:0] a);
    if (s == last_step(op)) begin
      if (op == OP_SECTOR) begin
        // only the upper lines pick the sector
        step_addr = {a[ADDR_W-1:SECTOR_BITS], {SECTOR_BITS{1'b0}}};
      end else if (op == OP_CHIP) begin
        step_addr = widen(CHIP_ERASE_ADDR);
      end else begin
        step_addr = a;
      end
    end else if (s == 3'h1 || s == 3'h4) begin
      step_addr = widen(UNLOCK_ADDR_B);
    end else begin
      step_addr = widen(UNLOCK_ADDR_A);
    end
  endfunction

  function automatic logic [7:0] step_data(input flash_op_e op, input logic [2:0] s,
                                           input logic [7:0] d);
    if (s == last_step(op)) begin
      step_data = (op == OP_SECTOR) ? SECTOR_ERASE_CODE :
                  (op == OP_CHIP)   ? CHIP_ERASE_CODE : d;
    end else if (s == 3'h1 || s == 3'h4) begin
      step_data = UNLOCK_CODE_B;
    end else if (s == 3'h2) begin
      step_data = (op == OP_PROG) ? PROG_SETUP : ERASE_SETUP;
    end else begin
      step_data = UNLOCK_CODE_A;
    end
  endfunction

  function automatic logic [TMR_W-1:0] op_limit(input flash_op_e op);
    op_limit = (op == OP_PROG)   ? TMR_W'(PROG_MAX_CYC) :
               (op == OP_SECTOR) ? TMR_W'(SECTOR_TIMEOUT) : TMR_W'(CHIP_TIMEOUT);
  endfunction

  // the byte a finished operation leaves behind
  function automatic logic [7:0] expected(input flash_op_e op, input logic [7:0] d);
    expected = (op == OP_PROG) ? d : ERASED_BYTE;
  endfunction

  logic       poll_ok;
  logic [7:0] exp_byte;

  // a select on a function call is not legal, so the expected byte gets a name
  assign exp_byte  = expected(state_ff.op, state_ff.data);
  assign poll_ok   = bc.rdata[7] == exp_byte[7];
  assign bc.req    = !state_ff.pend && (state_ff.st == ST_SEQ || state_ff.st == ST_POLL ||
                     state_ff.st == ST_CONFIRM || state_ff.st == ST_FINAL);
  // while an operation runs only reads go out, never another command
  assign bc.wr     = state_ff.st == ST_SEQ;
  assign bc.addr   = bc.wr ? step_addr(state_ff.op, state_ff.step, state_ff.addr)
                           : state_ff.addr;
  assign bc.wdata  = step_data(state_ff.op, state_ff.step, state_ff.data);

  always_comb begin
    nxt_ff           = state_ff;
    nxt_ff.rsp_valid = 1'b0;
    if (bc.req) begin
      nxt_ff.pend = 1'b1;
    end
    if (bc.done) begin
      nxt_ff.pend = 1'b0;
    end
    if ((state_ff.st == ST_POLL || state_ff.st == ST_CONFIRM || state_ff.st == ST_SETTLE) &&
        state_ff.tmr != {TMR_W{1'b1}}) begin
      nxt_ff.tmr = state_ff.tmr + TMR_W'(1);
    end
    case (state_ff.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          nxt_ff.op        = cmd_op;
          nxt_ff.addr      = (cmd_op == OP_CHIP) ? widen(CHIP_ERASE_ADDR) : cmd_addr;
          nxt_ff.data      = cmd_data;
          nxt_ff.step      = 3'h0;
          nxt_ff.rsp_error = 1'b0;
          nxt_ff.st        = (cmd_op == OP_READ) ? ST_FINAL : ST_SEQ;
        end
      end
      ST_SEQ: begin
        // the whole unlock run goes out unbroken, so it is never aborted
        if (bc.done) begin
          if (state_ff.step == last_step(state_ff.op)) begin
            nxt_ff.st  = ST_POLL;
            nxt_ff.tmr = '0;
          end else begin
            nxt_ff.step = state_ff.step + 3'h1;
          end
        end
      end
      ST_POLL: begin
        if (bc.done) begin
          if (poll_ok) begin
            nxt_ff.st   = ST_CONFIRM;
            nxt_ff.conf = 1'b0;
          end else if (state_ff.tmr >= op_limit(state_ff.op)) begin
            nxt_ff.st        = ST_IDLE;
            nxt_ff.rsp_valid = 1'b1;
            nxt_ff.rsp_error = 1'b1;
            nxt_ff.rsp_data  = bc.rdata;
          end
        end
      end
      ST_CONFIRM: begin
        // a poll that races completion is trusted only after two clean rereads
        if (bc.done) begin
          if (!poll_ok) begin
            nxt_ff.st = ST_POLL;
          end else if (state_ff.conf) begin
            nxt_ff.st  = ST_SETTLE;
            nxt_ff.tmr = '0;
          end else begin
            nxt_ff.conf = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (state_ff.tmr >= TMR_W'(SETTLE_CYC - 1)) begin
          nxt_ff.st = ST_FINAL;
        end
      end
      ST_FINAL: begin
        if (bc.done) begin
          nxt_ff.st        = ST_IDLE;
          nxt_ff.rsp_valid = 1'b1;
          nxt_ff.rsp_data  = bc.rdata;
          nxt_ff.rsp_error = (state_ff.op != OP_READ) &&
                             (bc.rdata != expected(state_ff.op, state_ff.data));
        end
      end
      default: begin
        nxt_ff.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_ff;
    end
  end

  assign cmd_ready = state_ff.st == ST_IDLE;
  assign busy      = state_ff.st != ST_IDLE;
  assign rsp_valid = state_ff.rsp_valid;
  assign rsp_data  = state_ff.rsp_data;
  assign rsp_error = state_ff.rsp_error;

  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clock  (clock),
    .rst_n  (rst_n),
    .bc     (bc.engine),
    .ce_n   (ce_n),
    .oe_n   (oe_n),
    .we_n   (we_n),
    .addr   (addr),
    .dq_out (dq_out),
    .dq_oe  (dq_oe),
    .dq_in  (dq_in)
  );
endmodule

// File: tb/flash_seq_monitor.sv
// port assertions for the flash write sequencer
`timescale 1ns/1ns
module flash_seq_monitor
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 19
) (
  // clock and reset
  input wire logic                      clock,
  input wire logic                      rst_n,
  // command and answer
  input wire logic                      cmd_valid,
  input wire logic                      cmd_ready,
  input wire flash_seq_pkg::flash_op_e  cmd_op,
  input wire logic [ADDR_W-1:0]         cmd_addr,
  input wire logic [7:0]                cmd_data,
  input wire logic                      rsp_valid,
  input wire logic                      rsp_error,
  // flash pins
  input wire logic                      ce_n,
  input wire logic                      oe_n,
  input wire logic                      we_n,
  input wire logic [ADDR_W-1:0]         addr,
  input wire logic [7:0]                dq_out,
  input wire logic                      dq_oe
);
  logic [2:0]        wcnt_ff;
  flash_op_e         op_ff;
  logic [ADDR_W-1:0] a_ff;
  logic [7:0]        d_ff;

  // write pulses per command; read before it steps at the rising strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_ff <= 3'h0;
      op_ff   <= OP_READ;
      a_ff    <= '0;
      d_ff    <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      wcnt_ff <= 3'h0;
      op_ff   <= cmd_op;
      a_ff    <= cmd_addr;
      d_ff    <= cmd_data;
    end else if ($rose(we_n)) begin
      wcnt_ff <= wcnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_we_ce; !we_n |-> !ce_n && oe_n && dq_oe; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe misqualified");
  property p_rd; !oe_n |-> !ce_n && we_n && !dq_oe; endproperty
  a_rd: assert property (p_rd) else $error("read strobe misqualified");
  property p_pulse;
    $fell(we_n) |-> ##1 we_n && !ce_n && dq_oe && $stable(addr) && $stable(dq_out);
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse shape");
  property p_first;
    $rose(we_n) && wcnt_ff == 3'h0 |-> addr == ADDR_W'(UNLOCK_ADDR_A) && dq_out == UNLOCK_CODE_A;
  endproperty
  a_first: assert property (p_first) else $error("first unlock write");
  property p_prog;
    $rose(we_n) && wcnt_ff == 3'h3 && op_ff == OP_PROG |-> addr == a_ff && dq_out == d_ff;
  endproperty
  a_prog: assert property (p_prog) else $error("program byte write");
  property p_sect;
    $rose(we_n) && wcnt_ff == 3'h5 && op_ff == OP_SECTOR |-> dq_out == SECTOR_ERASE_CODE
      && addr == {a_ff[ADDR_W-1:SECTOR_BITS], 12'h000};
  endproperty
  a_sect: assert property (p_sect) else $error("sector erase write");
  property p_chip;
    $rose(we_n) && wcnt_ff == 3'h5 && op_ff == OP_CHIP |->
      addr == ADDR_W'(CHIP_ERASE_ADDR) && dq_out == CHIP_ERASE_CODE;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase write");
  property p_count;
    rsp_valid |-> wcnt_ff == (op_ff == OP_PROG ? 3'h4 : op_ff == OP_READ ? 3'h0 : 3'h6);
  endproperty
  a_count: assert property (p_count) else $error("write count");
  property p_read; cmd_valid && cmd_ready && cmd_op == OP_READ |-> ##7 rsp_valid; endproperty
  a_read: assert property (p_read) else $error("read answer late");

  c_prog: cover property (rsp_valid && op_ff == OP_PROG);
  c_sect: cover property (rsp_valid && op_ff == OP_SECTOR);
  c_err: cover property (rsp_valid && rsp_error);
endmodule

bind flash_write_seq flash_seq_monitor #(.ADDR_W(ADDR_W)) mon (
  .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
  .rsp_error(rsp_error), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
  .dq_out(dq_out), .dq_oe(dq_oe)
);

// File: tb/flash_dev_model.sv
// behavioural byte-wide flash answering at its pins
`timescale 1ns/1ns
module flash_dev_model
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 19
) (
  // strobes and address
  input wire logic              ce_n,
  input wire logic              oe_n,
  input wire logic              we_n,
  input wire logic [ADDR_W-1:0] addr,
  // resolved data wire, erase slow-down
  input wire logic [7:0]        dq,
  input wire logic              slow,
  // read drive
  output logic [7:0]            dev_dq,
  output logic                  dev_oe
);
  logic [7:0]        mem [int];
  logic [ADDR_W-1:0] lat_addr;
  logic [7:0]        tgt_data = 8'h00;
  logic [7:0]        cur;
  logic              run = 1'b0;
  logic              erasing = 1'b0;
  logic              settling = 1'b0;
  logic              tgl = 1'b0;
  int                step = 0;

  function automatic logic [7:0] peek(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : ERASED_BYTE;
  endfunction

  task automatic start_op(input logic [ADDR_W-1:0] a, input logic [7:0] d, input int kind);
    #(kind == 1 ? 5000 : slow ? 100000 : kind == 2 ? 10000 : 15000);
    if (kind == 1) mem[a] = peek(a) & d;
    else foreach (mem[k]) if (kind == 3 || k[ADDR_W-1:12] == a[ADDR_W-1:12]) mem[k] = 8'hff;
    run = 1'b0;
    settling = 1'b1;
    #1000 settling = 1'b0;
  endtask

  task automatic take_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [15:0] lo;
    int          kind;
    lo = a[15:0];
    if (run) return;
    case (step)
      0, 3: step = (lo == UNLOCK_ADDR_A && d == UNLOCK_CODE_A) ? step + 1 : 0;
      1, 4: step = (lo == UNLOCK_ADDR_B && d == UNLOCK_CODE_B) ? step + 1 : 0;
      2: step = lo != UNLOCK_ADDR_A ? 0 : d == PROG_SETUP ? 6 : d == ERASE_SETUP ? 3 : 0;
      default: begin
        // internal operation and status bits start at this rising strobe
        if (step == 6 || d == SECTOR_ERASE_CODE || (d == CHIP_ERASE_CODE && lo == CHIP_ERASE_ADDR)) begin
          tgt_data = step == 6 ? d : ERASED_BYTE;
          erasing = step != 6;
          run = 1'b1;
          // kind is fixed now: step is cleared before the forked process runs
          kind = step == 6 ? 1 : d == SECTOR_ERASE_CODE ? 2 : 3;
          fork
            start_op(a, d, kind);
          join_none
        end
        step = 0;
      end
    endcase
  endtask

  assign dev_oe = !ce_n && !oe_n;
  always @(addr or run or settling or tgl) begin
    cur = peek(addr);
    if (run) dev_dq = {erasing ? 1'b0 : ~tgt_data[7], tgl, ~tgt_data[5:0]};
    else if (settling) dev_dq = {cur[7], ~cur[6:0]};
    else dev_dq = cur;
  end
  always @(negedge oe_n) if (!ce_n && run) tgl = ~tgl;
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) lat_addr = addr;
  always @(posedge we_n or posedge ce_n) if ((we_n ^ ce_n) && oe_n) take_write(lat_addr, dq);
endmodule

// File: tb/tb.sv
// self-checking bench: sequencer against a behavioural flash
`timescale 1ns/1ns
module tb;
  import flash_seq_pkg::*;
  localparam int ADDR_W = 19;
  typedef struct { logic [7:0] data; logic err; logic [7:0] mask; } note_s;

  logic              clock = 1'b0;
  logic              rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_error, busy, slow;
  logic              ce_n, oe_n, we_n, dq_oe, dev_oe;
  flash_op_e         cmd_op;
  logic [ADDR_W-1:0] cmd_addr, addr, a, b, c;
  logic [7:0]        cmd_data, rsp_data, dq_out, dq_in, dev_dq, d;
  logic [7:0]        fill = 8'h5a;
  logic [7:0]        shadow [int];
  note_s             notes [$];
  note_s             n;
  int                num_errors = 0;
  int                n_tests = 0;

  always #50 clock = ~clock;
  // undriven wire shows a changing pattern, never the last value
  always @(posedge clock) fill <= ~fill;
  assign dq_in = dq_oe ? dq_out : dev_oe ? dev_dq : fill;

  flash_write_seq #(.ADDR_W(ADDR_W), .SECTOR_TIMEOUT(400), .CHIP_TIMEOUT(400)) dut (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .busy(busy), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  flash_dev_model #(.ADDR_W(ADDR_W)) flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq(dq_in), .slow(slow),
    .dev_dq(dev_dq), .dev_oe(dev_oe));

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // called just after an edge; holds the request until taken
  task automatic run_cmd(input flash_op_e op, input logic [ADDR_W-1:0] ca,
                         input logic [7:0] cd, input logic [7:0] ed, input logic ee,
                         input logic [7:0] m);
    notes.push_back('{ed, ee, m});
    cmd_op = op;
    cmd_addr = ca;
    cmd_data = cd;
    cmd_valid = 1'b1;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    #5 cmd_valid = 1'b0;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      @(posedge clock);
      #5;
    end
    cmp_flag("busy", 1'b0, busy);
  endtask

  // answers are looked at mid-cycle, well away from the edge that launches them
  always @(negedge clock) begin
    if (rsp_valid === 1'b1) begin
      n = notes.pop_front();
      cmp_byte("rsp_data", n.data & n.mask, rsp_data & n.mask);
      cmp_flag("rsp_error", n.err, rsp_error);
    end
  end

  initial begin
    #2000000;
    num_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_data = 8'h00;
    slow = 1'b0;
    void'($urandom(7));
    repeat (16) @(posedge clock);
    #5 rst_n = 1'b1;
    a = ADDR_W'($urandom);
    run_cmd(OP_READ, a, 8'h00, ERASED_BYTE, 1'b0, 8'hff);
    run_cmd(OP_CHIP, a, 8'h00, ERASED_BYTE, 1'b0, 8'hff);
    for (int k = 0; k < 4; k++) begin
      a = ADDR_W'($urandom);
      d = 8'($urandom) & 8'h7f;
      shadow[a] = d;
      run_cmd(OP_PROG, a, d, d, 1'b0, 8'hff);
      run_cmd(OP_READ, a, 8'h00, d, 1'b0, 8'hff);
    end
    // overwrite without erase: cells only clear, poll never matches
    run_cmd(OP_PROG, a, ~shadow[a], 8'h00, 1'b1, 8'hff);
    b = a ^ 19'h01000;
    c = a ^ 19'h00fff;
    run_cmd(OP_PROG, b, 8'h12, 8'h12, 1'b0, 8'hff);
    run_cmd(OP_PROG, c, 8'h34, 8'h34, 1'b0, 8'hff);
    run_cmd(OP_SECTOR, a, 8'h00, ERASED_BYTE, 1'b0, 8'hff);
    run_cmd(OP_READ, c, 8'h00, ERASED_BYTE, 1'b0, 8'hff);
    run_cmd(OP_READ, b, 8'h00, 8'h12, 1'b0, 8'hff);
    slow = 1'b1;
    run_cmd(OP_CHIP, a, 8'h00, 8'h00, 1'b1, 8'h80);
    repeat (1100) @(posedge clock);
    #5 slow = 1'b0;
    run_cmd(OP_READ, b, 8'h00, ERASED_BYTE, 1'b0, 8'hff);
    @(posedge clock);
    #5;
    cmp_byte("pending", 8'h00, 8'(notes.size()));
    final_report();
  end
endmodule
